// File: rtl/vcsfm_regs.vh
`ifndef VCSFM_REGS_VH
`define VCSFM_REGS_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define VCSFM_CTRL       8'h00
`define VCSFM_SLOTS      8'h04
`define VCSFM_QOS        8'h10
`define VCSFM_SCHED      8'h20
`define VCSFM_STAT       8'h30
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VCSFM_CTRL_COLD  0
`define VCSFM_CTRL_FLUSH 1
`define VCSFM_CTRL_WARM  2
`define VCSFM_CTRL_BUSY  3
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VCSFM_SLOTS_RST  6'h20
`define VCSFM_QOS_RST    16'h0000
`define VCSFM_SCHED_RST  32'hffffffff
// ----------------------------------------------------------------------
// Characters, frame and credit counts, bus answers
// ----------------------------------------------------------------------
`define VCSFM_CH_EOP     9'h100
`define VCSFM_CH_EEP     9'h101
`define VCSFM_CH_FILL    9'h102
`define VCSFM_FRAME      256
`define VCSFM_FCT_STEP   16'h0100
`define VCSFM_RESP_OK    2'b00
`define VCSFM_RESP_ERR   2'b10
`endif

// File: rtl/vcsfm_top.v
`timescale 1ns/10ps
`include "vcsfm_regs.vh"
module vcsfm_top #(
	parameter NVC         = 4,
	parameter OBUF_DEPTH  = 256,
	parameter IBUF_DEPTH  = 1024,
	parameter VW          = $clog2(NVC)
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire              ce,
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              hw_valid,
	input  wire [VW-1:0]     hw_vc,
	input  wire [8:0]        hw_char,
	output wire              hw_ready,
	input  wire              hr_en,
	input  wire [VW-1:0]     hr_vc,
	output reg  [8:0]        hr_char,
	output reg               hr_char_valid,
	output wire [NVC-1:0]    hr_avail,
	output reg               tx_valid,
	output reg  [VW-1:0]     tx_vc,
	output reg  [8:0]        tx_char,
	output reg               tx_last,
	input  wire              tx_ready,
	input  wire              rx_valid,
	input  wire [VW-1:0]     rx_vc,
	input  wire [8:0]        rx_char,
	input  wire              fct_rx_valid,
	input  wire [VW-1:0]     fct_rx_vc,
	output wire              fct_tx_req,
	output wire [VW-1:0]     fct_tx_vc,
	input  wire              fct_tx_ack,
	input  wire              slot_tick,
	input  wire [4:0]        slot_num
);
	localparam OAW = $clog2(OBUF_DEPTH);
	localparam IAW = $clog2(IBUF_DEPTH);
	localparam [OAW:0] FRAME_O = `VCSFM_FRAME;
	localparam [OAW:0] OFULL   = OBUF_DEPTH;
	localparam [IAW:0] STEP_I  = `VCSFM_FRAME;
	localparam [IAW:0] CAP_I   = IBUF_DEPTH;
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_SEND = 2'd1;
	localparam [1:0] ST_PAD  = 2'd2;

	// ------------------------------------------------------------------
	// Storage and shared state
	// ------------------------------------------------------------------
	reg  [8:0]     omem [0:NVC*OBUF_DEPTH-1];
	reg  [8:0]     imem [0:NVC*IBUF_DEPTH-1];
	reg  [15:0]    qos_r [0:NVC-1];
	reg  [31:0]    sched_r [0:NVC-1];
	reg  [5:0]     slot_count;
	reg  [4:0]     cur_slot;
	reg            ctrl_cold;
	reg            ctrl_flush;
	reg            ctrl_warm;
	reg  [1:0]     state;
	reg  [VW-1:0]  cur_vc;
	reg  [8:0]     remain;
	reg  [1:0]     npad;
	reg  [8:0]     flen_r;
	reg  [VW-1:0]  rr;
	wire [OAW-1:0] owp_w [0:NVC-1];
	wire [OAW-1:0] orp_w [0:NVC-1];
	wire [IAW-1:0] iwp_w [0:NVC-1];
	wire [IAW-1:0] irp_w [0:NVC-1];
	wire [8:0]     len_w [0:NVC-1];
	wire [8:0]     flen_w [0:NVC-1];
	wire [31:0]    stat_w [0:NVC-1];
	wire [NVC-1:0] elig;
	wire [NVC-1:0] ofull;
	wire [NVC-1:0] fct_want;
	wire cold = !aresetn || (ce && ctrl_cold);
	wire kill = cold || (ce && ctrl_flush);
	wire hw_fire = hw_valid && hw_ready;
	wire hr_fire = hr_en && hr_avail[hr_vc];
	wire out_free = !tx_valid || tx_ready;
	wire rd_fire = (state == ST_SEND) && out_free;
	wire [8:0] rd_char = omem[{cur_vc, orp_w[cur_vc]}];
	wire last_char = (remain == 9'h001);
	wire frame_done = out_free && ((state == ST_SEND && last_char &&
		npad == 2'b00) || (state == ST_PAD && npad == 2'b01));
	reg  [VW-1:0]  best_vc;
	reg  [11:0]    best_p;
	reg            best_ok;
	reg  [VW-1:0]  fct_sel;
	integer        i;
	integer        k;
	integer        j;

	assign hw_ready = !ofull[hw_vc];
	assign fct_tx_req = |fct_want;
	assign fct_tx_vc = fct_sel;
	wire fct_fire = fct_tx_req && fct_tx_ack;

	// ------------------------------------------------------------------
	// Per-channel counters
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NVC; g = g + 1) begin : vc
			localparam [VW-1:0] ID = g;
			reg  [OAW:0]   ocnt;
			reg  [OAW:0]   oeop;
			reg  [OAW-1:0] owp;
			reg  [OAW-1:0] orp;
			reg  [15:0]    cred;
			reg  [IAW:0]   ispc;
			reg  [IAW:0]   ifill;
			reg  [IAW-1:0] iwp;
			reg  [IAW-1:0] irp;
			wire o_wr  = hw_fire && (hw_vc == ID);
			wire o_rd  = rd_fire && (cur_vc == ID);
			wire e_in  = o_wr && hw_char[8] && !hw_char[1];
			wire e_out = o_rd && rd_char[8] && !rd_char[1];
			wire i_wr  = rx_valid && (rx_vc == ID);
			wire i_rd  = hr_fire && (hr_vc == ID);
			wire f_out = fct_fire && (fct_sel == ID);
			wire f_in  = fct_rx_valid && (fct_rx_vc == ID);
			wire done  = frame_done && (cur_vc == ID);
			wire big   = ocnt >= FRAME_O;
			wire rdy   = big || (oeop != {(OAW+1){1'b0}});
			wire [1:0] pad = 2'b00 - len_w[g][1:0];
			// A short frame carries everything held; credit below 256
			// then still lets such a frame out if it covers the padded length.
			assign len_w[g] = big ? 9'h100 : ocnt[8:0];
			assign flen_w[g] = len_w[g] + {7'h00, pad};
			assign elig[g] = rdy && (cred >= {7'h00, flen_w[g]}) &&
				sched_r[g][cur_slot];
			assign fct_want[g] = ispc >= STEP_I;
			assign ofull[g] = ocnt == OFULL;
			assign hr_avail[g] = ifill != {(IAW+1){1'b0}};
			assign owp_w[g] = owp;
			assign orp_w[g] = orp;
			assign iwp_w[g] = iwp;
			assign irp_w[g] = irp;
			assign stat_w[g] = {{(15-IAW){1'b0}}, ispc, cred};
			always @(posedge aclk) begin
				if (kill) begin
					ocnt  <= {(OAW+1){1'b0}};
					oeop  <= {(OAW+1){1'b0}};
					owp   <= {OAW{1'b0}};
					orp   <= {OAW{1'b0}};
					cred  <= 16'h0000;
					ispc  <= CAP_I;
					ifill <= {(IAW+1){1'b0}};
					iwp   <= {IAW{1'b0}};
					irp   <= {IAW{1'b0}};
				end else if (ce) begin
					if (o_wr)
						owp <= owp + 1'b1;
					if (o_rd)
						orp <= orp + 1'b1;
					ocnt <= ocnt + {{OAW{1'b0}}, o_wr} -
						{{OAW{1'b0}}, o_rd};
					oeop <= oeop + {{OAW{1'b0}}, e_in} -
						{{OAW{1'b0}}, e_out};
					cred <= cred + (f_in ? `VCSFM_FCT_STEP : 16'h0000) -
						(done ? {7'h00, flen_r} : 16'h0000);
					// Writes do not consume space: it was reserved when
					// the token went out.
					ispc <= ispc + {{IAW{1'b0}}, i_rd} -
						(f_out ? STEP_I : {(IAW+1){1'b0}});
					ifill <= ifill + {{IAW{1'b0}}, i_wr} -
						{{IAW{1'b0}}, i_rd};
					if (i_wr)
						iwp <= iwp + 1'b1;
					if (i_rd)
						irp <= irp + 1'b1;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Buffer memories
	// ------------------------------------------------------------------
	always @(posedge aclk) begin
		if (ce) begin
			if (hw_fire)
				omem[{hw_vc, owp_w[hw_vc]}] <= hw_char;
			if (rx_valid)
				imem[{rx_vc, iwp_w[rx_vc]}] <= rx_char;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			hr_char       <= 9'h000;
			hr_char_valid <= 1'b0;
		end else if (ce) begin
			hr_char_valid <= hr_fire;
			if (hr_fire)
				hr_char <= imem[{hr_vc, irp_w[hr_vc]}];
		end
	end

	// ------------------------------------------------------------------
	// Access control and token arbitration
	// ------------------------------------------------------------------
	always @* begin
		best_ok = 1'b0;
		best_vc = {VW{1'b0}};
		best_p  = 12'h000;
		for (i = 0; i < NVC; i = i + 1) begin
			if (elig[i] && (!best_ok || qos_r[i][11:0] > best_p)) begin
				best_ok = 1'b1;
				best_vc = i[VW-1:0];
				best_p  = qos_r[i][11:0];
			end
		end
	end

	always @* begin
		fct_sel = rr;
		for (k = NVC; k > 0; k = k - 1) begin
			if (fct_want[rr + k[VW-1:0]])
				fct_sel = rr + k[VW-1:0];
		end
	end

	always @(posedge aclk) begin
		if (cold)
			rr <= {VW{1'b0}};
		else if (ce && fct_fire)
			rr <= fct_sel;
	end

	always @(posedge aclk) begin
		if (!aresetn)
			cur_slot <= 5'h00;
		else if (ce && slot_tick)
			cur_slot <= ({1'b0, slot_num} < slot_count) ? slot_num : 5'h00;
	end

	// ------------------------------------------------------------------
	// Frame sender
	// ------------------------------------------------------------------
	// Arbitration runs only between frames, so a frame granted late in
	// a slot runs on into the next one until it is done.
	always @(posedge aclk) begin
		if (kill || (ce && ctrl_warm)) begin
			state    <= ST_IDLE;
			cur_vc   <= {VW{1'b0}};
			remain   <= 9'h000;
			npad     <= 2'b00;
			flen_r   <= 9'h000;
			tx_valid <= 1'b0;
			tx_vc    <= {VW{1'b0}};
			tx_char  <= 9'h000;
			tx_last  <= 1'b0;
		end else if (ce) begin
			case (state)
			ST_IDLE: begin
				if (out_free)
					tx_valid <= 1'b0;
				if (best_ok) begin
					state  <= ST_SEND;
					cur_vc <= best_vc;
					remain <= len_w[best_vc];
					flen_r <= flen_w[best_vc];
					npad   <= flen_w[best_vc][1:0] - len_w[best_vc][1:0];
				end
			end
			ST_SEND: begin
				if (out_free) begin
					tx_valid <= 1'b1;
					tx_vc    <= cur_vc;
					tx_char  <= rd_char;
					tx_last  <= last_char && (npad == 2'b00);
					remain   <= remain - 9'h001;
					if (last_char)
						state <= (npad == 2'b00) ? ST_IDLE : ST_PAD;
				end
			end
			ST_PAD: begin
				if (out_free) begin
					tx_valid <= 1'b1;
					tx_char  <= `VCSFM_CH_FILL;
					tx_last  <= npad == 2'b01;
					npad     <= npad - 2'b01;
					if (npad == 2'b01)
						state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	reg         aw_ok;
	reg  [7:0]  aw_a;
	reg         w_ok;
	reg  [31:0] w_d;
	reg  [3:0]  w_s;
	wire do_wr = aw_ok && w_ok && !s_axi_bvalid;
	wire [31:0] wm = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
	wire [VW-1:0] wvc = aw_a[VW+1:2];
	wire w_vc_ok = aw_a[3:2] < NVC;
	wire [VW-1:0] rvc = s_axi_araddr[VW+1:2];
	wire r_vc_ok = s_axi_araddr[3:2] < NVC;
	wire [7:0] w_base = {aw_a[7:4], 4'h0};
	wire [7:0] r_base = {s_axi_araddr[7:4], 4'h0};
	assign s_axi_awready = !aw_ok;
	assign s_axi_wready  = !w_ok;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok        <= 1'b0;
			aw_a         <= 8'h00;
			w_ok         <= 1'b0;
			w_d          <= 32'h00000000;
			w_s          <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `VCSFM_RESP_OK;
			ctrl_cold    <= 1'b0;
			ctrl_flush   <= 1'b0;
			ctrl_warm    <= 1'b0;
		end else if (ce) begin
			ctrl_cold  <= 1'b0;
			ctrl_flush <= 1'b0;
			ctrl_warm  <= 1'b0;
			if (s_axi_awvalid && !aw_ok) begin
				aw_ok <= 1'b1;
				aw_a  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_ok) begin
				w_ok <= 1'b1;
				w_d  <= s_axi_wdata;
				w_s  <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_wr) begin
				aw_ok        <= 1'b0;
				w_ok         <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `VCSFM_RESP_OK;
				if (aw_a == `VCSFM_CTRL && w_s[0]) begin
					ctrl_cold  <= w_d[`VCSFM_CTRL_COLD];
					ctrl_flush <= w_d[`VCSFM_CTRL_FLUSH];
					ctrl_warm  <= w_d[`VCSFM_CTRL_WARM];
				end else if (!(aw_a == `VCSFM_SLOTS ||
					((w_base == `VCSFM_QOS || w_base == `VCSFM_SCHED ||
					w_base == `VCSFM_STAT) && w_vc_ok)))
					s_axi_bresp <= `VCSFM_RESP_ERR;
			end
		end
	end

	// Configuration survives warm reset and flush; only cold reset
	// returns every channel to best effort over all slots.
	always @(posedge aclk) begin
		if (cold) begin
			slot_count <= `VCSFM_SLOTS_RST;
			for (j = 0; j < NVC; j = j + 1) begin
				qos_r[j]   <= `VCSFM_QOS_RST;
				sched_r[j] <= `VCSFM_SCHED_RST;
			end
		end else if (ce && do_wr) begin
			if (aw_a == `VCSFM_SLOTS && w_s[0])
				slot_count <= w_d[5:0];
			if (w_base == `VCSFM_QOS && w_vc_ok)
				qos_r[wvc] <= (qos_r[wvc] & ~wm[15:0]) |
					(w_d[15:0] & wm[15:0]);
			if (w_base == `VCSFM_SCHED && w_vc_ok)
				sched_r[wvc] <= (sched_r[wvc] & ~wm) | (w_d & wm);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `VCSFM_RESP_OK;
		end else if (ce) begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `VCSFM_RESP_OK;
				s_axi_rdata  <= 32'h00000000;
				if (s_axi_araddr == `VCSFM_CTRL)
					s_axi_rdata[`VCSFM_CTRL_BUSY] <= state != ST_IDLE;
				else if (s_axi_araddr == `VCSFM_SLOTS)
					s_axi_rdata <= {19'h00000, cur_slot, 2'b00, slot_count};
				else if (r_base == `VCSFM_QOS && r_vc_ok)
					s_axi_rdata <= {16'h0000, qos_r[rvc]};
				else if (r_base == `VCSFM_SCHED && r_vc_ok)
					s_axi_rdata <= sched_r[rvc];
				else if (r_base == `VCSFM_STAT && r_vc_ok)
					s_axi_rdata <= stat_w[rvc];
				else
					s_axi_rresp <= `VCSFM_RESP_ERR;
			end
		end
	end
endmodule // vcsfm_top

// File: tb/vcsfm_props.sv
`timescale 1ns/10ps
`include "vcsfm_regs.vh"
// ----
// Frame, token and bus checks
// ----
module vcsfm_props #(parameter NVC = 4, localparam VW = $clog2(NVC)) (
	input logic          aclk,
	input logic          aresetn,
	input logic          ce,
	input logic          s_axi_awvalid,
	input logic          s_axi_awready,
	input logic          s_axi_wvalid,
	input logic          s_axi_wready,
	input logic [1:0]    s_axi_bresp,
	input logic          s_axi_bvalid,
	input logic          s_axi_bready,
	input logic          s_axi_arvalid,
	input logic          s_axi_arready,
	input logic          s_axi_rvalid,
	input logic          hr_en,
	input logic [VW-1:0] hr_vc,
	input logic          hr_char_valid,
	input logic [NVC-1:0] hr_avail,
	input logic          tx_valid,
	input logic [8:0]    tx_char,
	input logic          tx_last,
	input logic          tx_ready,
	input logic          fct_tx_req,
	input logic          fct_tx_ack
);
	// Beats taken so far in the running frame
	logic [8:0] beats;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			beats <= 9'h000;
		else if (tx_valid && tx_ready)
			beats <= tx_last ? 9'h000 : beats + 9'h001;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence beat_s; tx_valid && tx_ready; endsequence
	sequence fill_s; tx_valid && tx_char == `VCSFM_CH_FILL; endsequence
	sequence both_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	pad_multiple_a: assert property (beat_s ##0 tx_last |-> beats[1:0] == 2'b11)
		else $error("frame length not a multiple of four");
	frame_max_a: assert property (beat_s ##0 tx_last |-> beats < 9'h100)
		else $error("frame longer than 256");
	fill_tail_a: assert property (beat_s ##0 fill_s ##0 !tx_last |=> ##[0:4] fill_s)
		else $error("data after a fill");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char) && $stable(tx_last))
		else $error("frame char dropped while stalled");
	fct_hold_a: assert property (fct_tx_req && !fct_tx_ack |=> fct_tx_req)
		else $error("token request withdrawn");
	reset_state_a: assert property ($rose(aresetn) |-> !tx_valid && fct_tx_req && hr_avail == '0)
		else $error("bad state after reset");
	read_data_a: assert property (ce && hr_en && hr_avail[hr_vc] |=> hr_char_valid)
		else $error("host read not answered");
	read_empty_a: assert property (ce && !(hr_en && hr_avail[hr_vc]) |=> !hr_char_valid)
		else $error("host read answered from nothing");
	wr_answer_a: assert property (both_s |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule // vcsfm_props

bind vcsfm_top vcsfm_props #(.NVC(NVC)) u_props (.*);

// File: tb/vcsfm_far_end.sv
`timescale 1ns/10ps
// ----
// Remote link end: takes frames, sends tokens and chars
// ----
module vcsfm_far_end (
	input  logic       aclk,
	input  logic       aresetn,
	input  logic       tx_valid,
	input  logic [8:0] tx_char,
	input  logic       tx_last,
	output logic       tx_ready = 1'b0,
	input  logic       fct_tx_req,
	input  logic [1:0] fct_tx_vc,
	output logic       fct_tx_ack = 1'b0,
	output logic       fct_rx_valid = 1'b0,
	output logic [1:0] fct_rx_vc = 2'b00,
	output logic       rx_valid = 1'b0,
	output logic [1:0] rx_vc = 2'b00,
	output logic [8:0] rx_char = 9'h000
);
	logic       slow = 1'b0;
	logic       fct_en = 1'b0;
	logic [9:0] got[$];
	logic [1:0] fct_log[$];
	// Slow mode stalls every other cycle to test holding
	always @(posedge aclk) begin
		if (tx_valid && tx_ready)
			got.push_back({tx_last, tx_char});
		if (fct_tx_req && fct_tx_ack)
			fct_log.push_back(fct_tx_vc);
		tx_ready <= aresetn && (!slow || !tx_ready);
		fct_tx_ack <= aresetn && fct_en && fct_tx_req && !fct_tx_ack;
	end
	// Idle lines show the inverse so stale values never match
	task automatic send_fct(input logic [1:0] v);
		@(posedge aclk);
		fct_rx_valid <= 1'b1;
		fct_rx_vc <= v;
		@(posedge aclk);
		fct_rx_valid <= 1'b0;
		fct_rx_vc <= ~v;
	endtask
	task automatic send_rx(input logic [1:0] v, input logic [8:0] c);
		@(posedge aclk);
		rx_valid <= 1'b1;
		rx_vc <= v;
		rx_char <= c;
		@(posedge aclk);
		rx_valid <= 1'b0;
		rx_vc <= ~v;
		rx_char <= ~c;
	endtask
endmodule // vcsfm_far_end

// File: tb/tb_vc_segment_flow_mac.sv
`timescale 1ns/10ps
`include "vcsfm_regs.vh"
module tb_vc_segment_flow_mac;
	// ----
	// Signals and instances
	// ----
	logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, tx_vc, rx_vc, fct_rx_vc;
	logic [1:0]  hw_vc = 2'b00, hr_vc = 2'b00, fct_tx_vc;
	logic        hw_valid = 1'b0, hr_en = 1'b0, slot_tick = 1'b0;
	logic [8:0]  hw_char = 9'h000, hr_char, tx_char, rx_char;
	logic [4:0]  slot_num = 5'h00;
	logic [3:0]  hr_avail;
	logic        hw_ready, hr_char_valid, tx_valid, tx_last, tx_ready;
	logic        rx_valid, fct_rx_valid, fct_tx_req, fct_tx_ack;
	int          n_errors = 0, n_checks = 0;
	vcsfm_top #(.NVC(4), .OBUF_DEPTH(256), .IBUF_DEPTH(1024)) dut (.*);
	vcsfm_far_end u_far (.*);
	always #2.5 aclk = ~aclk;
	// ----
	// Bus and host tasks
	// ----
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100 && !(s_axi_bvalid && s_axi_bready); n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk("write done", 1, n < 100);
		chk("bresp", `VCSFM_RESP_OK, s_axi_bresp);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100 && !(s_axi_rvalid && s_axi_rready); n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk("read done", 1, n < 100);
		chk("rresp", r, s_axi_rresp);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		axi_rd(a, d, `VCSFM_RESP_OK);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic host_wr(input logic [1:0] v, input logic [8:0] c);
		int n;
		@(posedge aclk);
		hw_valid <= 1'b1;
		hw_vc <= v;
		hw_char <= c;
		for (n = 0; n < 100 && !(hw_valid && hw_ready); n++)
			@(posedge aclk);
		hw_valid <= 1'b0;
	endtask
	task automatic host_rd(input logic [1:0] v, input logic [8:0] e);
		@(posedge aclk);
		hr_en <= 1'b1;
		hr_vc <= v;
		@(posedge aclk);
		hr_en <= 1'b0;
		@(posedge aclk);
		chk("hr_char_valid", 1, hr_char_valid);
		chk("hr_char", e, hr_char);
	endtask
	task automatic wait_got(input int k);
		for (int n = 0; n < 900 && u_far.got.size() < k; n++)
			@(posedge aclk);
		chk("frame chars", k, u_far.got.size());
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		logic [31:0] d;
		chk("hr_avail", 0, hr_avail);
		for (int v = 0; v < 4; v++) begin
			rd_chk(`VCSFM_STAT + 8'(4 * v), 32'h04000000);
			rd_chk(`VCSFM_SCHED + 8'(4 * v), 32'hffffffff);
			rd_chk(`VCSFM_QOS + 8'(4 * v), 32'h00000000);
		end
		axi_wr(`VCSFM_QOS, 32'h00000305);
		rd_chk(`VCSFM_QOS, 32'h00000305);
		rd_chk(`VCSFM_QOS + 8'h04, 32'h00000000);
		// Only byte 1 enabled: the other lanes must keep their value
		s_axi_wstrb <= 4'h2;
		axi_wr(`VCSFM_QOS + 8'h04, 32'h0000ffff);
		s_axi_wstrb <= 4'hf;
		rd_chk(`VCSFM_QOS + 8'h04, 32'h0000ff00);
		axi_rd(8'h40, d, `VCSFM_RESP_ERR);
		chk("unmapped data", 0, d);
		$display("test reset done");
	endtask
	task automatic t_fct_tx;
		u_far.fct_en <= 1'b1;
		for (int n = 0; n < 400 && fct_tx_req; n++)
			@(posedge aclk);
		chk("token count", 16, u_far.fct_log.size());
		for (int n = 1; n < 16; n++)
			chk("token order", 2'(u_far.fct_log[n-1] + 1), u_far.fct_log[n]);
		rd_chk(`VCSFM_STAT + 8'h0c, 32'h00000000);
		$display("test token send done");
	endtask
	task automatic t_rx;
		logic [8:0] cs[3] = '{9'h041, 9'h042, `VCSFM_CH_FILL};
		for (int i = 0; i < 3; i++)
			u_far.send_rx(2'd1, cs[i]);
		@(posedge aclk);
		chk("hr_avail", 4'b0010, hr_avail);
		for (int i = 0; i < 3; i++)
			host_rd(2'd1, cs[i]);
		rd_chk(`VCSFM_STAT + 8'h04, 32'h00030000);
		$display("test receive done");
	endtask
	task automatic t_frame;
		u_far.slow <= 1'b1;
		u_far.send_fct(2'd0);
		rd_chk(`VCSFM_STAT, 32'h00000100);
		host_wr(2'd0, 9'h041);
		host_wr(2'd0, `VCSFM_CH_EOP);
		wait_got(4);
		chk("short frame", {10'h041, 10'h100, 10'h102, 10'h302},
			{u_far.got[0], u_far.got[1], u_far.got[2], u_far.got[3]});
		rd_chk(`VCSFM_STAT, 32'h000000fc);
		$display("test short frame done");
	endtask
	task automatic t_full;
		u_far.got.delete();
		u_far.send_fct(2'd2);
		for (int n = 0; n < 255; n++)
			host_wr(2'd2, 9'(n));
		repeat (20) @(posedge aclk);
		chk("early frame", 0, u_far.got.size());
		host_wr(2'd2, 9'h0ff);
		wait_got(256);
		chk("frame end", 10'h2ff, u_far.got[255]);
		rd_chk(`VCSFM_STAT + 8'h08, 32'h00000000);
		$display("test full frame done");
	endtask
	task automatic tick(input logic [4:0] s);
		@(posedge aclk);
		slot_tick <= 1'b1;
		slot_num <= s;
		@(posedge aclk);
		slot_tick <= 1'b0;
	endtask
	task automatic t_sched;
		u_far.got.delete();
		axi_wr(`VCSFM_SCHED + 8'h04, 32'h00000002);
		tick(5'd0);
		host_wr(2'd1, 9'h042);
		host_wr(2'd1, `VCSFM_CH_EOP);
		repeat (40) @(posedge aclk);
		chk("sent without credit", 0, u_far.got.size());
		u_far.send_fct(2'd1);
		repeat (40) @(posedge aclk);
		chk("sent outside slot", 0, u_far.got.size());
		tick(5'd1);
		rd_chk(`VCSFM_SLOTS, 32'h00000120);
		wait_got(4);
		$display("test schedule done");
	endtask
	task automatic t_resets;
		u_far.fct_en <= 1'b0;
		// A token arriving while the clock enable is low must be lost
		@(posedge aclk);
		ce <= 1'b0;
		u_far.send_fct(2'd3);
		@(posedge aclk);
		ce <= 1'b1;
		rd_chk(`VCSFM_STAT + 8'h0c, 32'h00000000);
		axi_wr(`VCSFM_CTRL, 32'h00000004);
		rd_chk(`VCSFM_STAT, 32'h000000fc);
		axi_wr(`VCSFM_CTRL, 32'h00000002);
		rd_chk(`VCSFM_STAT, 32'h04000000);
		rd_chk(`VCSFM_QOS, 32'h00000305);
		axi_wr(`VCSFM_CTRL, 32'h00000001);
		rd_chk(`VCSFM_QOS, 32'h00000000);
		rd_chk(`VCSFM_SCHED + 8'h04, 32'hffffffff);
		$display("test resets done");
	endtask
	// ----
	// Run control
	// ----
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Generous span: the tests need under two thousand cycles
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_fct_tx();
		t_rx();
		t_frame();
		t_full();
		t_sched();
		t_resets();
		end_of_test();
	end
endmodule // tb_vc_segment_flow_mac
